// ===== pkg/serial_audio_pkg.sv
// constants, format enumeration and shared decoders for the serial audio pin port
package serial_audio_pkg;

    typedef enum logic [2:0] {
        FMT_I2S,
        FMT_LEFT,
        FMT_RIGHT,
        FMT_TDM_CLOCK,
        FMT_TDM_PULSE
    } fmt_e;

    // register byte offsets
    localparam logic [7:0] REG_IN_CTRL = 8'h00;
    localparam logic [7:0] REG_OUT_CTRL = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_RX_BASE = 8'h40;
    localparam logic [7:0] REG_TX_BASE = 8'h80;

    // control field positions
    localparam int FMT_LSB = 0;
    localparam int RJ_LSB = 3;
    localparam int MASTER_BIT = 5;
    localparam int DIV_LSB = 8;
    localparam int DIV_W = 8;

    // values after reset: two-channel i2s, slave, half bit period of two cycles
    localparam logic [4:0] IN_CTRL_RST = 5'h00;
    localparam logic [15:0] OUT_CTRL_RST = 16'h0200;

    // frame geometry in bit clocks
    localparam logic [4:0] WORD_MAX = 5'd24;
    localparam logic [5:0] SLOT_LEN = 6'd32;
    localparam logic [7:0] FRAME_MASK_2CH = 8'h3f;
    localparam logic [7:0] FRAME_MASK_TDM = 8'hff;
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam int LINES = 4;
    localparam int SLOTS = 8;

    // pin positions on the shared pins
    localparam int PIN_IN0 = 0;
    localparam int PIN_IN_LR = 4;
    localparam int PIN_OUT0 = 6;
    localparam int PIN_OUT_LR = 10;
    localparam int PIN_OUT_BCLK = 11;
    localparam int PINS = 12;

    function automatic logic is_tdm(input fmt_e f);
        return (f == FMT_TDM_CLOCK) || (f == FMT_TDM_PULSE);
    endfunction

    // word clock level that opens a frame: falling edge formats open low
    function automatic logic first_level(input fmt_e f);
        return !((f == FMT_I2S) || (f == FMT_TDM_CLOCK));
    endfunction

    function automatic logic [4:0] word_len(input fmt_e f, input logic [1:0] rj);
        if (f != FMT_RIGHT) begin
            return WORD_MAX;
        end
        case (rj)
            2'd0: return 5'd24;
            2'd1: return 5'd20;
            default: return 5'd16;
        endcase
    endfunction

    function automatic logic [4:0] msb_offset(input fmt_e f, input logic [1:0] rj);
        logic [5:0] gap;
        gap = SLOT_LEN - {1'b0, word_len(f, rj)};
        case (f)
            FMT_LEFT: return 5'd0;
            FMT_RIGHT: return gap[4:0];
            default: return 5'd1;
        endcase
    endfunction

    function automatic fmt_e to_fmt(input logic [2:0] v);
        return (v > 3'd4) ? FMT_I2S : fmt_e'(v);
    endfunction

endpackage

// ===== design/sync_2ff.sv
// two flip-flop synchroniser, also used as a reset release synchroniser
`timescale 1ns/1ps
module sync_2ff #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;

    // the first stage is read by the second stage only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// ===== design/rx_word_lane.sv
// one serial input line: msb-first accumulator and left-aligned word latch
`timescale 1ns/1ps
module rx_word_lane (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic bit_in,
    input wire logic start,
    input wire logic shift_en,
    input wire logic emit,
    input wire logic [4:0] nbits,
    output logic [23:0] word_out
);
    logic [23:0] acc_q;
    logic [23:0] acc_d;
    logic [23:0] word_d;

    always_comb begin
        acc_d = acc_q;
        word_d = word_out;
        if (emit) begin
            // short words land msb-aligned so the sign stays on bit 23
            word_d = acc_q << (5'd24 - nbits);
        end
        if (start) begin
            acc_d = {23'h00_0000, bit_in};
        end else if (shift_en) begin
            acc_d = {acc_q[22:0], bit_in};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= '0;
            word_out <= '0;
        end else begin
            acc_q <= acc_d;
            word_out <= word_d;
        end
    end
endmodule

// ===== design/serial_audio_pin_port.sv
// serial audio input and output ports on the twelve shared function pins
`timescale 1ns/1ps
//
// Summary of operation
// R01 - pins zero to five carry serial input
// R02 - pins six to eleven carry serial output
// R03 - input port clocks are always slave
// R04 - output clocks selectable master or slave
// R05 - input lines sampled by input clocks
// R06 - output lines shifted by output clocks
// R07 - slave adc: master output clocks looped externally
// R08 - external dac served by output port only
// R09 - data changes falling, captured rising bit clock
// R10 - i2s: frame at falling, msb one later
// R11 - left-justified: frame at rising, msb aligned
// R12 - right-justified: msb delayed 8/12/16 bit clocks
// R13 - tdm clock: frame at falling, msb one later
// R14 - tdm pulse: frame at rising, msb one later
// R15 - twos complement words, msb first
// R16 - left channel word precedes right word
// R17 - tdm slots 0-3 first half, 4-7 second
// R18 - up to 24 bits kept, extras truncated
module serial_audio_pin_port (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic in_bit_clk,
    input wire logic [serial_audio_pkg::PINS-1:0] shared_function_pin_i,
    output logic [serial_audio_pkg::PINS-1:0] shared_function_pin_o,
    output logic [serial_audio_pkg::PINS-1:0] shared_function_pin_oe,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);
    import serial_audio_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // resets
    logic rst_n;
    logic rx_rst_n;

    sync_2ff #(.WIDTH(1)) u_sys_rst (
        .clk(clk_sys),
        .rst_n(nrst),
        .d(1'b1),
        .q(rst_n)
    );

    // the link clock may stop between frames; its reset release waits for edges
    sync_2ff #(.WIDTH(1)) u_rx_rst (
        .clk(in_bit_clk),
        .rst_n(rst_n),
        .d(1'b1),
        .q(rx_rst_n)
    );

    ////////////////////////////////////////////////////////////////////////////
    // register file state
    logic [4:0] in_ctrl_q;
    logic [4:0] in_ctrl_d;
    logic [15:0] out_ctrl_q;
    logic [15:0] out_ctrl_d;
    logic [23:0] tx_mem_q [SLOTS];
    logic [23:0] tx_mem_d [SLOTS];
    logic [23:0] rx_mem_q [SLOTS];
    logic [23:0] rx_mem_d [SLOTS];
    logic [15:0] rx_count_q;
    logic [15:0] rx_count_d;
    logic [15:0] tx_frames_q;
    logic [15:0] tx_frames_d;
    logic [31:0] rdata_d;

    fmt_e in_fmt;
    fmt_e out_fmt;
    logic out_master;
    logic [7:0] out_div;

    assign in_fmt = to_fmt(in_ctrl_q[FMT_LSB +: 3]);
    assign out_fmt = to_fmt(out_ctrl_q[FMT_LSB +: 3]);
    assign out_master = out_ctrl_q[MASTER_BIT];
    assign out_div = out_ctrl_q[DIV_LSB +: DIV_W];

    ////////////////////////////////////////////////////////////////////////////
    // input port, clocked by the input bit clock
    logic [4:0] rx_cfg;
    fmt_e rx_fmt;
    logic [1:0] rx_rj;
    logic rx_lr;
    logic [LINES-1:0] rx_data;
    logic rx_lr_q;
    logic [7:0] rx_cnt_q;
    logic [7:0] rx_cnt_d;
    logic [4:0] rx_nbits_q;
    logic [4:0] rx_nbits_d;
    logic [2:0] rx_slot_q;
    logic [2:0] rx_slot_d;
    logic [2:0] rx_hold_slot_q;
    logic [2:0] rx_hold_slot_d;
    logic rx_toggle_q;
    logic rx_toggle_d;
    logic rx_start;
    logic rx_shift_en;
    logic rx_emit;
    logic [23:0] rx_word [LINES];

    // control is static while the port runs; each bit is resynchronised alone
    sync_2ff #(.WIDTH(5)) u_rx_cfg (
        .clk(in_bit_clk),
        .rst_n(rx_rst_n),
        .d(in_ctrl_q),
        .q(rx_cfg)
    );

    assign rx_fmt = to_fmt(rx_cfg[FMT_LSB +: 3]);
    assign rx_rj = rx_cfg[RJ_LSB +: 2];
    // word clock and data are launched by the same bit clock, so no synchroniser
    assign rx_lr = shared_function_pin_i[PIN_IN_LR]; // [R03] [R05]
    assign rx_data = shared_function_pin_i[PIN_IN0 +: LINES]; // [R01] [R05]

    always_comb begin
        logic edge_seen;
        logic restart;
        logic [7:0] n;
        logic [8:0] p;
        logic [4:0] wmax;
        edge_seen = 1'b0;
        restart = 1'b0;
        n = '0;
        p = '0;
        wmax = word_len(rx_fmt, rx_rj);
        edge_seen = rx_lr != rx_lr_q;
        // tdm counts a whole frame from its opening edge; two-channel restarts per half
        if (is_tdm(rx_fmt)) begin
            restart = edge_seen && (rx_lr == first_level(rx_fmt)); // [R13] [R14]
        end else begin
            restart = edge_seen; // [R10] [R11] [R12]
        end
        if (restart) begin
            n = '0;
        end else if (rx_cnt_q == CNT_MAX) begin
            n = CNT_MAX;
        end else begin
            n = rx_cnt_q + 8'h01;
        end
        p = {1'b0, n} - {4'h0, msb_offset(rx_fmt, rx_rj)}; // [R10] [R11] [R12] [R13] [R14]
        rx_start = !p[8] && (p[4:0] == 5'd0) && (is_tdm(rx_fmt) || (p[7:5] == 3'd0));
        rx_emit = rx_start && (rx_nbits_q != 5'd0);
        // bits past the word length are dropped without any flag
        rx_shift_en = !rx_start && (rx_nbits_q != 5'd0) && (rx_nbits_q < wmax); // [R18]
        rx_cnt_d = n;
        rx_nbits_d = rx_nbits_q;
        rx_slot_d = rx_slot_q;
        rx_hold_slot_d = rx_hold_slot_q;
        rx_toggle_d = rx_toggle_q;
        if (rx_emit) begin
            rx_hold_slot_d = rx_slot_q;
            rx_toggle_d = !rx_toggle_q;
        end
        if (rx_start) begin
            rx_nbits_d = 5'd1;
            if (is_tdm(rx_fmt)) begin
                rx_slot_d = p[7:5]; // [R17]
            end else begin
                rx_slot_d = {2'b00, rx_lr != first_level(rx_fmt)}; // [R16]
            end
        end else if (rx_shift_en) begin
            rx_nbits_d = rx_nbits_q + 5'd1;
        end
    end

    // [R09] capture on the rising bit clock edge
    always_ff @(posedge in_bit_clk or negedge rx_rst_n) begin
        if (!rx_rst_n) begin
            rx_lr_q <= 1'b0;
            rx_cnt_q <= '0;
            rx_nbits_q <= '0;
            rx_slot_q <= '0;
            rx_hold_slot_q <= '0;
            rx_toggle_q <= 1'b0;
        end else begin
            rx_lr_q <= rx_lr;
            rx_cnt_q <= rx_cnt_d;
            rx_nbits_q <= rx_nbits_d;
            rx_slot_q <= rx_slot_d;
            rx_hold_slot_q <= rx_hold_slot_d;
            rx_toggle_q <= rx_toggle_d;
        end
    end

    generate
        for (genvar l = 0; l < LINES; l++) begin : g_lane
            rx_word_lane u_lane (
                .clk(in_bit_clk),
                .rst_n(rx_rst_n),
                .bit_in(rx_data[l]),
                .start(rx_start),
                .shift_en(rx_shift_en),
                .emit(rx_emit),
                .nbits(rx_nbits_q),
                .word_out(rx_word[l]) // [R15]
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // word hand-over into the system clock domain
    // held words stay put for at least eight bit clocks, far longer than the crossing
    logic rx_toggle_s;
    logic rx_toggle_seen_q;
    logic rx_new;

    sync_2ff #(.WIDTH(1)) u_rx_tog (
        .clk(clk_sys),
        .rst_n(rst_n),
        .d(rx_toggle_q),
        .q(rx_toggle_s)
    );

    assign rx_new = rx_toggle_s != rx_toggle_seen_q;

    ////////////////////////////////////////////////////////////////////////////
    // output port, system clock domain
    logic [1:0] out_pins_s;
    logic obclk_s;
    logic olr_s;
    logic obclk_prev_q;
    logic olr_prev_q;
    logic olr_prev_d;
    logic [7:0] div_cnt_q;
    logic [7:0] div_cnt_d;
    logic mbclk_q;
    logic mbclk_d;
    logic mlr_q;
    logic mlr_d;
    logic [7:0] fcnt_q;
    logic [7:0] fcnt_d;
    logic [LINES-1:0] tx_bits_q;
    logic [LINES-1:0] tx_bits_d;
    logic tx_rise;
    logic tx_fall;
    logic tx_frame_open;

    // slave clocks come from another party and are resynchronised first
    sync_2ff #(.WIDTH(2)) u_out_clk (
        .clk(clk_sys),
        .rst_n(rst_n),
        .d(shared_function_pin_i[PIN_OUT_LR +: 2]),
        .q(out_pins_s)
    );

    assign olr_s = out_pins_s[0];
    assign obclk_s = out_pins_s[1];

    always_comb begin
        logic [7:0] half;
        logic toggle;
        logic [7:0] mask;
        logic [7:0] n;
        logic [8:0] p;
        logic [5:0] ph;
        logic [4:0] bp;
        logic [4:0] wl;
        logic [2:0] entry;
        logic ok;
        half = (out_div == 8'h00) ? 8'h01 : out_div;
        toggle = div_cnt_q >= (half - 8'h01);
        mask = is_tdm(out_fmt) ? FRAME_MASK_TDM : FRAME_MASK_2CH;
        wl = word_len(out_fmt, out_ctrl_q[RJ_LSB +: 2]);
        div_cnt_d = toggle ? 8'h00 : div_cnt_q + 8'h01;
        mbclk_d = toggle ? !mbclk_q : mbclk_q;
        if (out_master) begin
            tx_rise = toggle && !mbclk_q; // [R04]
            tx_fall = toggle && mbclk_q;
        end else begin
            tx_rise = obclk_s && !obclk_prev_q;
            tx_fall = !obclk_s && obclk_prev_q;
        end
        tx_frame_open = !out_master && (olr_s != olr_prev_q) && (olr_s == first_level(out_fmt));
        // word clock moves on the falling edge, so compare against its level at the last rise
        olr_prev_d = tx_rise ? olr_s : olr_prev_q;
        fcnt_d = fcnt_q;
        if (tx_rise) begin
            // in slave mode the frame is assumed 64 or 256 bit clocks long
            fcnt_d = tx_frame_open ? 8'h00 : (fcnt_q + 8'h01) & mask;
        end
        // index of the bit that the coming falling edge launches
        n = (fcnt_q + 8'h01) & mask;
        mlr_d = mlr_q;
        tx_bits_d = tx_bits_q;
        p = '0;
        ph = '0;
        bp = '0;
        entry = '0;
        ok = 1'b0;
        if (is_tdm(out_fmt)) begin
            p = {1'b0, n} - {4'h0, msb_offset(out_fmt, out_ctrl_q[RJ_LSB +: 2])};
            bp = p[4:0];
            entry = p[7:5]; // [R17]
            ok = !p[8] && (bp < wl);
        end else begin
            ph = {1'b0, n[4:0]} - {1'b0, msb_offset(out_fmt, out_ctrl_q[RJ_LSB +: 2])};
            bp = ph[4:0];
            ok = !ph[5] && (bp < wl); // [R18]
        end
        if (tx_fall) begin
            case (out_fmt)
                FMT_I2S: mlr_d = n[5]; // [R10]
                FMT_LEFT: mlr_d = !n[5]; // [R11]
                FMT_RIGHT: mlr_d = !n[5]; // [R12]
                FMT_TDM_CLOCK: mlr_d = n[7]; // [R13]
                FMT_TDM_PULSE: mlr_d = n == 8'h00; // [R14]
                default: mlr_d = n[5];
            endcase
            for (int l = 0; l < LINES; l++) begin
                if (is_tdm(out_fmt)) begin
                    tx_bits_d[l] = (l == 0) && ok && tx_mem_q[entry][5'd23 - bp];
                end else begin
                    // left word fills the first half of the frame
                    tx_bits_d[l] = ok && tx_mem_q[{2'(l), n[5]}][5'd23 - bp]; // [R15] [R16]
                end
            end
        end
    end

    // [R06] [R09] output data only moves on the falling bit clock edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            obclk_prev_q <= 1'b0;
            olr_prev_q <= 1'b0;
            div_cnt_q <= '0;
            mbclk_q <= 1'b0;
            mlr_q <= 1'b0;
            fcnt_q <= '0;
            tx_bits_q <= '0;
            rx_toggle_seen_q <= 1'b0;
        end else begin
            obclk_prev_q <= obclk_s;
            olr_prev_q <= olr_prev_d;
            div_cnt_q <= div_cnt_d;
            mbclk_q <= mbclk_d;
            mlr_q <= mlr_d;
            fcnt_q <= fcnt_d;
            tx_bits_q <= tx_bits_d;
            rx_toggle_seen_q <= rx_toggle_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pins
    always_comb begin
        shared_function_pin_o = '0;
        shared_function_pin_oe = '0; // [R01] [R03]
        shared_function_pin_o[PIN_OUT0 +: LINES] = tx_bits_q; // [R02] [R08]
        shared_function_pin_oe[PIN_OUT0 +: LINES] = '1; // [R02]
        shared_function_pin_o[PIN_OUT_LR] = mlr_q;
        shared_function_pin_o[PIN_OUT_BCLK] = mbclk_q;
        // master clocks may be looped back to the input clock pins for a slave adc
        shared_function_pin_oe[PIN_OUT_LR] = out_master; // [R04] [R07]
        shared_function_pin_oe[PIN_OUT_BCLK] = out_master; // [R04] [R07]
    end

    ////////////////////////////////////////////////////////////////////////////
    // register bus and captured words
    always_comb begin
        logic hit_rx;
        logic hit_tx;
        hit_rx = (reg_addr[7:5] == REG_RX_BASE[7:5]) && (reg_addr[1:0] == 2'b00);
        hit_tx = (reg_addr[7:5] == REG_TX_BASE[7:5]) && (reg_addr[1:0] == 2'b00);
        in_ctrl_d = in_ctrl_q;
        out_ctrl_d = out_ctrl_q;
        tx_mem_d = tx_mem_q;
        rx_mem_d = rx_mem_q;
        rx_count_d = rx_count_q;
        tx_frames_d = tx_frames_q;
        rdata_d = '0;
        if (reg_wr) begin
            if (reg_addr == REG_IN_CTRL) begin
                in_ctrl_d = reg_wdata[4:0];
            end
            if (reg_addr == REG_OUT_CTRL) begin
                out_ctrl_d = {reg_wdata[15:8], 2'b00, reg_wdata[5:0]};
            end
            if (hit_tx) begin
                tx_mem_d[reg_addr[4:2]] = reg_wdata[23:0];
            end
        end
        if (reg_rd) begin
            if (reg_addr == REG_IN_CTRL) begin
                rdata_d = {27'h000_0000, in_ctrl_q};
            end else if (reg_addr == REG_OUT_CTRL) begin
                rdata_d = {16'h0000, out_ctrl_q};
            end else if (reg_addr == REG_STATUS) begin
                rdata_d = {tx_frames_q, rx_count_q};
            end else if (hit_rx) begin
                rdata_d = {8'h00, rx_mem_q[reg_addr[4:2]]};
            end else if (hit_tx) begin
                rdata_d = {8'h00, tx_mem_q[reg_addr[4:2]]};
            end
        end
        if (rx_new) begin
            rx_count_d = rx_count_q + 16'h0001;
            for (int l = 0; l < LINES; l++) begin
                if (is_tdm(in_fmt)) begin
                    if (l == 0) begin
                        rx_mem_d[rx_hold_slot_q] = rx_word[0]; // [R17]
                    end
                end else begin
                    rx_mem_d[{2'(l), rx_hold_slot_q[0]}] = rx_word[l]; // [R16]
                end
            end
        end
        if (tx_fall && (((fcnt_q + 8'h01) & (is_tdm(out_fmt) ? FRAME_MASK_TDM
                : FRAME_MASK_2CH)) == 8'h00)) begin
            tx_frames_d = tx_frames_q + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            in_ctrl_q <= IN_CTRL_RST;
            out_ctrl_q <= OUT_CTRL_RST;
            rx_count_q <= '0;
            tx_frames_q <= '0;
            reg_rdata <= '0;
            for (int i = 0; i < SLOTS; i++) begin
                tx_mem_q[i] <= '0;
                rx_mem_q[i] <= '0;
            end
        end else begin
            in_ctrl_q <= in_ctrl_d;
            out_ctrl_q <= out_ctrl_d;
            rx_count_q <= rx_count_d;
            tx_frames_q <= tx_frames_d;
            reg_rdata <= rdata_d;
            tx_mem_q <= tx_mem_d;
            rx_mem_q <= rx_mem_d;
        end
    end
endmodule

// ===== tb/serial_audio_pin_port_props.sv
// concurrent checks on the serial audio pin port boundary
`timescale 1ns/1ps
module serial_audio_pin_port_props
    import serial_audio_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [11:0] shared_function_pin_o,
    input wire logic [11:0] shared_function_pin_oe,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata
);
    logic [11:0] o;
    logic [11:0] oe;
    logic tdm_q;
    logic tdm_d;
    assign o = shared_function_pin_o;
    assign oe = shared_function_pin_oe;
    //////////////////////////////////////////
    // tracks whether the output port was last set to a tdm format
    always_comb begin
        tdm_d = tdm_q;
        if (reg_wr && reg_addr == REG_OUT_CTRL) begin
            tdm_d = reg_wdata[2:0] == 3'h3 || reg_wdata[2:0] == 3'h4;
        end
    end
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tdm_q <= 1'b0;
        end else begin
            tdm_q <= tdm_d;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    //////////////////////////////////////////
    a_data_pins_out: assert property (oe[9:6] == 4'hf)
        else $error("serial output lines not driven");
    a_in_pins_off: assert property (oe[3:0] == 4'h0 && o[5:0] == 6'h00)
        else $error("input pins driven");
    a_in_clk_slave: assert property (oe[5:4] == 2'b00)
        else $error("input clocks driven");
    a_clk_mode: assert property (reg_wr && reg_addr == REG_OUT_CTRL
        |=> oe[11:10] == {2{$past(reg_wdata[5])}})
        else $error("output clock drive does not follow master bit");
    a_data_on_fall: assert property ($changed(o[9:6]) && oe[11] && $past(oe[11]) |-> !o[11])
        else $error("serial data changed while bit clock high");
    a_wc_on_fall: assert property ($changed(o[10]) && oe[10] && $past(oe[10]) |-> !o[11])
        else $error("word clock changed while bit clock high");
    a_tdm_one_line: assert property (tdm_q && $past(tdm_q, 64) |-> o[9:7] == 3'b000)
        else $error("tdm drives more than line zero");
    a_word_narrow: assert property ($past(reg_rd) && $past(reg_addr) >= REG_RX_BASE
        |-> reg_rdata[31:24] == 8'h00)
        else $error("audio word wider than 24 bits");
    c_master_run: cover property (oe[11] && $rose(o[11]));
    c_rx_read: cover property (reg_rd && reg_addr == REG_RX_BASE);
    c_tdm_run: cover property (tdm_q && oe[11]);
endmodule
bind serial_audio_pin_port serial_audio_pin_port_props i_props (.clk_sys(clk_sys), .nrst(nrst),
    .shared_function_pin_o(shared_function_pin_o), .shared_function_pin_oe(shared_function_pin_oe),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

// ===== tb/audio_source_model.sv
// behavioural external serial audio source feeding the input port
`timescale 1ns/1ps
module audio_source_model (
    output logic bclk,
    output logic lrck,
    output logic [3:0] sd
);
    logic [23:0] w [8];
    initial begin
        bclk = 1'b0;
        lrck = 1'b0;
        sd = 4'h0;
    end
    //////////////////////////////////////////
    // clock stands low between bursts; idle bits show the inverse level
    task automatic play(input int nfr, input logic i2s, input int off, input int len);
        logic open;
        open = !i2s;
        lrck = !open;
        repeat (4) begin // rx reset release needs bit clock edges
            bclk = 1'b0;
            #24;
            bclk = 1'b1;
            #24;
        end
        // one extra half frame so the last right word gets handed over
        for (int h = 0; h <= 2 * nfr; h++) begin
            for (int k = 0; k < 32; k++) begin
                bclk = 1'b0;
                if (k == 0) lrck = h[0] ? !open : open;
                for (int l = 0; l < 4; l++) begin
                    sd[l] = (k >= off && k < off + len) ? w[2 * l + h[0]][23 - k + off] : !sd[l];
                end
                #24;
                bclk = 1'b1;
                #24;
            end
        end
        bclk = 1'b0;
        sd = ~sd;
    endtask
endmodule

// ===== tb/serial_audio_pin_port_tb.sv
// self-checking bench for the serial audio pin port
`timescale 1ns/1ps
module serial_audio_pin_port_tb;
    import serial_audio_pkg::*;
    logic clk_sys, nrst, reg_wr, reg_rd, bclk, lrck, pb, plr, lj;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd_v;
    logic [11:0] pin_i, pin_o, pin_oe;
    logic [3:0] sd;
    logic [23:0] lfsr, sh [4], cap [8], tw [8];
    int failures, samples_checked, cycles, idx, mo;
    int ictl [5] = '{0, 1, 2, 10, 18};
    int offs [5] = '{1, 0, 8, 12, 16};
    int lens [5] = '{24, 24, 24, 20, 16};
    assign pin_i = {6'h00, bclk, lrck, sd};
    serial_audio_pin_port i_dut (.clk_sys(clk_sys), .nrst(nrst), .in_bit_clk(bclk),
        .shared_function_pin_i(pin_i), .shared_function_pin_o(pin_o),
        .shared_function_pin_oe(pin_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    audio_source_model src (.bclk(bclk), .lrck(lrck), .sd(sd));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    //////////////////////////////////////////
    function automatic logic [23:0] rnd24();
        repeat (24) lfsr = {lfsr[22:0], lfsr[23] ^ lfsr[22] ^ lfsr[21] ^ lfsr[16]};
        return lfsr;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        rd_v = reg_rdata;
    endtask
    task automatic print_verdict();
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    //////////////////////////////////////////
    // far-end receiver: samples the output lines on rising bit clock
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            print_verdict();
        end
        pb <= pin_o[11];
        if (pin_o[11] && !pb) begin
            idx = (pin_o[10] !== plr) ? 0 : idx + 1;
            plr = pin_o[10];
            for (int l = 0; l < 4; l++) begin
                if (idx >= mo && idx < mo + 24) sh[l] = {sh[l][22:0], pin_o[6 + l]};
                if (idx == mo + 23) cap[2 * l + (plr ^ lj)] = sh[l];
            end
        end
    end
    initial begin
        {nrst, reg_wr, reg_rd, reg_addr, reg_wdata, lj, mo} = '0;
        lfsr = 24'h00_07f3;
        repeat (10) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd(REG_OUT_CTRL);
        chk(rd_v, 32'h0000_0200);
        rd(8'h0c);
        chk(rd_v, 32'h0000_0000);
        chk({20'h0_0000, pin_oe}, 32'h0000_03c0);
        for (int c = 0; c < 5; c++) begin
            for (int i = 0; i < 8; i++) src.w[i] = rnd24();
            wr(REG_IN_CTRL, 32'(ictl[c]));
            src.play(2, c == 0, offs[c], lens[c]);
            repeat (20) @(posedge clk_sys);
            for (int i = 0; i < 8; i++) begin
                rd(REG_RX_BASE + 8'(4 * i));
                chk(rd_v, {8'h00, src.w[i] & (24'hff_ffff << (24 - lens[c]))});
            end
            $display("rx case %0d done", c);
        end
        for (int f = 0; f < 3; f++) begin
            lj = f != 0;
            mo = f ? 8 * (f - 1) : 1;
            for (int i = 0; i < 8; i++) begin
                tw[i] = rnd24();
                wr(REG_TX_BASE + 8'(4 * i), {8'h00, tw[i]});
            end
            wr(REG_OUT_CTRL, 32'h0000_0220 | 32'(f));
            repeat (800) @(posedge clk_sys);
            chk({20'h0_0000, pin_oe}, 32'h0000_0fc0);
            for (int i = 0; i < 8; i++) chk({8'h00, cap[i]}, {8'h00, tw[i]});
            $display("tx case %0d done", f);
        end
        for (int t = 3; t < 5; t++) begin
            wr(REG_OUT_CTRL, 32'h0000_0220 | 32'(t));
            repeat (300) @(posedge clk_sys);
        end
        $display("tdm run done");
        print_verdict();
    end
endmodule
